/* File: src/spi_host_cfg.svh */
// Offsets, field positions, reset values and counts of the serial frame host.
// Assumes a device whose serial master is reached through an 8-bit register port.
`ifndef SPI_HOST_CFG_SVH
`define SPI_HOST_CFG_SVH

// Device registers behind the device's own register port.
`define DEV_REG_CFG        8'h00
`define DEV_REG_TX         8'h01
`define DEV_REG_RX         8'h02
`define DEV_REG_EXE        8'h03

// Fields of the device configuration and execute bytes.
`define CFG_NB_LSB         0
`define CFG_EN_BIT         3
`define CFG_SS_BIT         4
`define CFG_CPOL_BIT       5
`define CFG_CPHA_BIT       6
`define EXE_GO_BIT         0
`define EXE_GO_VAL         8'h01

// Host registers on the Avalon-MM slave, byte addresses.
`define HR_CTRL            5'h00
`define HR_LEN             5'h04
`define HR_TX              5'h08
`define HR_STAT            5'h0C
`define HR_RX              5'h10
`define HR_SNOOP           5'h14

// Control and status fields.
`define CTRL_START_BIT     0
`define CTRL_CPOL_BIT      1
`define CTRL_CPHA_BIT      2
`define CTRL_KEEP_BIT      3
`define STAT_BUSY_BIT      0
`define STAT_DONE_BIT      1
`define STAT_ERR_BIT       2
`define STAT_CNT_LSB       8

// Reset values and counts.
`define CTRL_RST           3'h0
`define LEN_RST            6'h08
`define WORD_RST           32'h0000_0000
`define LEN_MAX            6'h20
`define CHUNK_BITS         4'h8

`endif

/* File: src/spi_host_pkg.sv */
// Types shared by the serial frame host files.
// Assumes the constants of spi_host_cfg.svh.
package spi_host_pkg;

  typedef enum logic [3:0] {
    S_IDLE   = 4'b0000,
    S_ENABLE = 4'b0001,
    S_TX     = 4'b0010,
    S_CFG    = 4'b0011,
    S_EXE    = 4'b0100,
    S_POLL   = 4'b0101,
    S_RX     = 4'b0110,
    S_END    = 4'b0111,
    S_DONE   = 4'b1000
  } seq_state_t;

endpackage : spi_host_pkg

/* File: src/pin_sync.sv */
// Two-stage synchroniser with edge detection for pins from outside CORE_CLK.
// Assumes asynchronous inputs; edges come in the same cycle as the synchronised level.
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 4
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst,
  // Pins and results.
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  ////////////////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_q;
    logic sync_q;
    logic last_q;
    // Only the second stage reads the first, so metastability stays contained.
    always_ff @(posedge clk) begin
      if (rst) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
        last_q <= 1'b0;
      end else begin
        meta_q <= pin[i];
        sync_q <= meta_q;
        last_q <= sync_q;
      end
    end
    assign lvl[i]  = sync_q;
    assign rise[i] = sync_q & ~last_q;
    assign fall[i] = ~sync_q & last_q;
  end

endmodule : pin_sync

/* File: src/dev_reg_access.sv */
// One access on the device register port, held until the device acknowledges.
// Assumes the device answers with a one-cycle ack on CORE_CLK.
`timescale 1ns/1ns
module dev_reg_access (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Request from the sequencer.
  input  wire logic       req,
  input  wire logic       req_wr,
  input  wire logic [7:0] req_addr,
  input  wire logic [7:0] req_wdata,
  output logic            done,
  output logic      [7:0] rdata,
  // Device register port.
  output logic            dev_write,
  output logic            dev_read,
  output logic      [7:0] dev_addr,
  output logic      [7:0] dev_wdata,
  input  wire logic       dev_ack,
  input  wire logic [7:0] dev_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      dev_write <= 1'b0;
      dev_read  <= 1'b0;
      dev_addr  <= 8'h00;
      dev_wdata <= 8'h00;
      done      <= 1'b0;
      rdata     <= 8'h00;
    end else begin
      done <= 1'b0;
      if ((dev_write || dev_read) && dev_ack) begin
        dev_write <= 1'b0;
        dev_read  <= 1'b0;
        done      <= 1'b1;
        rdata     <= dev_rdata;
      end else if (req && !dev_write && !dev_read) begin
        dev_write <= req_wr;
        dev_read  <= !req_wr;
        dev_addr  <= req_addr;
        dev_wdata <= req_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_hold_access;
    @(posedge clk) disable iff (rst)
      (dev_write || dev_read) && !dev_ack |=>
        $stable(dev_addr) && $stable(dev_wdata) && (dev_write || dev_read);
  endproperty
  a_hold_access : assert property (p_hold_access) else $error("access dropped early");

endmodule : dev_reg_access

/* File: src/spi_frame_host.sv */
// Host that builds serial frames of 1 to 32 bits through a device's serial master.
// Assumes Avalon-MM software access and a device register port on CORE_CLK;
// the serial pins are only observed, asynchronously, to check the shifting.
//
// How it works
// - phase picks leading or trailing sample edge
// - mode 0,0: sample rising, change falling
// - mode 0,1: sample falling, change rising
// - mode 1,0: sample falling, change rising
// - mode 1,1: sample rising, change falling
// - host writes configuration before every trigger
// - select change and trigger in separate writes
// - select held across chunks, raised to end unless keep is set
// - board pull-up keeps select high early
// - receive register read back per transfer
`timescale 1ns/1ns
`include "spi_host_cfg.svh"
module spi_frame_host (
  // Clock and reset.
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  // Avalon-MM slave.
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Device register port.
  output logic      [7:0]  DEV_ADDR,
  output logic      [7:0]  DEV_WDATA,
  output logic             DEV_WRITE,
  output logic             DEV_READ,
  input  wire logic [7:0]  DEV_RDATA,
  input  wire logic        DEV_ACK,
  // Observed serial pins.
  input  wire logic        SPI_SCLK,
  input  wire logic        SPI_MOSI,
  input  wire logic        SPI_MISO,
  input  wire logic        SPI_SS_N
);

  spi_host_pkg::seq_state_t state_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        cpol_q;
  logic        cpha_q;
  logic        keep_q;
  logic [5:0]  len_q;
  logic [31:0] tx_q;
  logic [31:0] rx_q;
  logic [5:0]  left_q;
  logic        done_q;
  logic        err_q;
  logic        pend_q;
  logic [3:0]  cnt_q;
  logic [7:0]  mosi_snoop_q;
  logic [7:0]  miso_snoop_q;
  logic [7:0]  last_wr_q;
  logic [7:0]  last_cfg_q;
  logic        take_wr;
  logic        start_ok;
  logic [3:0]  chunk;
  logic [5:0]  left_d;
  logic [8:0]  low_mask;
  logic        need_acc;
  logic        req;
  logic        req_wr;
  logic [7:0]  req_addr;
  logic [7:0]  req_data;
  logic [7:0]  cfg_byte;
  logic        acc_done;
  logic [7:0]  acc_rdata;
  logic [3:0]  pin_lvl;
  logic [3:0]  pin_rise;
  logic [3:0]  pin_fall;
  logic        samp;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : be_merge

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then the answer; writes land on that edge.
  assign take_wr  = AVS_WRITE && !wait_q;
  assign start_ok = take_wr && (AVS_ADDRESS == `HR_CTRL) && AVS_BYTEENABLE[0]
                    && AVS_WRITEDATA[`CTRL_START_BIT] && (state_q == spi_host_pkg::S_IDLE)
                    && (len_q != 6'h00) && (len_q <= `LEN_MAX);

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      wait_q  <= 1'b1;
      rdata_q <= `WORD_RST;
    end else if ((AVS_READ || AVS_WRITE) && wait_q) begin
      wait_q <= 1'b0;
      unique case (AVS_ADDRESS)
        `HR_CTRL:  rdata_q <= {28'h000_0000, keep_q, cpha_q, cpol_q, 1'b0};
        `HR_LEN:   rdata_q <= {26'h000_0000, len_q};
        `HR_TX:    rdata_q <= tx_q;
        `HR_STAT:  rdata_q <= {20'h0_0000, cnt_q, 5'h00, err_q, done_q,
                              state_q != spi_host_pkg::S_IDLE};
        `HR_RX:    rdata_q <= rx_q;
        `HR_SNOOP: rdata_q <= {16'h0000, miso_snoop_q, mosi_snoop_q};
        default:   rdata_q <= `WORD_RST;
      endcase
    end else begin
      wait_q <= 1'b1;
    end
  end

  assign AVS_WAITREQUEST = wait_q;
  assign AVS_READDATA    = rdata_q;

  // Setup registers are frozen while a frame runs, so a frame is never torn.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      {keep_q, cpha_q, cpol_q} <= `CTRL_RST;
      len_q <= `LEN_RST;
      tx_q  <= `WORD_RST;
    end else if (take_wr && state_q == spi_host_pkg::S_IDLE) begin
      if (AVS_ADDRESS == `HR_CTRL && AVS_BYTEENABLE[0]) begin
        cpol_q <= AVS_WRITEDATA[`CTRL_CPOL_BIT];
        cpha_q <= AVS_WRITEDATA[`CTRL_CPHA_BIT];
        keep_q <= AVS_WRITEDATA[`CTRL_KEEP_BIT];
      end
      if (AVS_ADDRESS == `HR_LEN && AVS_BYTEENABLE[0]) begin
        len_q <= AVS_WRITEDATA[5:0];
      end
      if (AVS_ADDRESS == `HR_TX) begin
        tx_q <= be_merge(tx_q, AVS_WRITEDATA, AVS_BYTEENABLE);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Chunking: the most significant bits go first, 8 at a time, the rest last.
  always_comb begin
    chunk    = (left_q > 6'h08) ? `CHUNK_BITS : left_q[3:0];
    left_d   = left_q - {2'b00, chunk};
    low_mask = (9'h001 << chunk) - 9'h001;
    cfg_byte = 8'h00;
    cfg_byte[`CFG_EN_BIT]   = 1'b1;
    cfg_byte[`CFG_CPOL_BIT] = cpol_q;
    cfg_byte[`CFG_CPHA_BIT] = cpha_q;
    need_acc = 1'b1;
    req_wr   = 1'b1;
    req_addr = `DEV_REG_CFG;
    req_data = cfg_byte;
    unique case (state_q)
      spi_host_pkg::S_ENABLE: begin
        // Select goes high in the enabling write itself, so no slave is picked early.
        req_data[`CFG_SS_BIT] = 1'b1;
      end
      spi_host_pkg::S_TX: begin
        req_addr = `DEV_REG_TX;
        req_data = 8'(tx_q >> left_d);
      end
      spi_host_pkg::S_CFG: begin
        req_data[`CFG_NB_LSB +: 3] = chunk[2:0];
      end
      spi_host_pkg::S_EXE: begin
        req_addr = `DEV_REG_EXE;
        req_data = `EXE_GO_VAL;
      end
      spi_host_pkg::S_POLL: begin
        req_wr   = 1'b0;
        req_addr = `DEV_REG_EXE;
      end
      spi_host_pkg::S_RX: begin
        req_wr   = 1'b0;
        req_addr = `DEV_REG_RX;
      end
      spi_host_pkg::S_END: begin
        req_data[`CFG_SS_BIT] = 1'b1;
      end
      default: begin
        need_acc = 1'b0;
      end
    endcase
    req = need_acc && !pend_q && !acc_done;
  end

  dev_reg_access u_access (
    .clk       (CORE_CLK),
    .rst       (RESET),
    .req       (req),
    .req_wr    (req_wr),
    .req_addr  (req_addr),
    .req_wdata (req_data),
    .done      (acc_done),
    .rdata     (acc_rdata),
    .dev_write (DEV_WRITE),
    .dev_read  (DEV_READ),
    .dev_addr  (DEV_ADDR),
    .dev_wdata (DEV_WDATA),
    .dev_ack   (DEV_ACK),
    .dev_rdata (DEV_RDATA)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state_q <= spi_host_pkg::S_IDLE;
    end else begin
      unique case (state_q)
        spi_host_pkg::S_IDLE:   if (start_ok) state_q <= spi_host_pkg::S_ENABLE;
        spi_host_pkg::S_ENABLE: if (acc_done) state_q <= spi_host_pkg::S_TX;
        spi_host_pkg::S_TX:     if (acc_done) state_q <= spi_host_pkg::S_CFG;
        spi_host_pkg::S_CFG:    if (acc_done) state_q <= spi_host_pkg::S_EXE;
        spi_host_pkg::S_EXE:    if (acc_done) state_q <= spi_host_pkg::S_POLL;
        spi_host_pkg::S_POLL: begin
          if (acc_done && !acc_rdata[`EXE_GO_BIT]) begin
            state_q <= spi_host_pkg::S_RX;
          end
        end
        spi_host_pkg::S_RX: begin
          if (acc_done) begin
            if (left_d != 6'h00) begin
              state_q <= spi_host_pkg::S_TX;
            end else if (keep_q) begin
              state_q <= spi_host_pkg::S_DONE;
            end else begin
              state_q <= spi_host_pkg::S_END;
            end
          end
        end
        spi_host_pkg::S_END:    if (acc_done) state_q <= spi_host_pkg::S_DONE;
        spi_host_pkg::S_DONE:   state_q <= spi_host_pkg::S_IDLE;
        default:                state_q <= spi_host_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      pend_q     <= 1'b0;
      last_wr_q  <= 8'h00;
      last_cfg_q <= 8'h00;
    end else begin
      if (acc_done) begin
        pend_q <= 1'b0;
      end else if (req) begin
        pend_q <= 1'b1;
      end
      if (req && req_wr) begin
        last_wr_q <= req_addr;
        if (req_addr == `DEV_REG_CFG) begin
          last_cfg_q <= req_data;
        end
      end
    end
  end

  // The receive byte is read after every chunk, since the next one overwrites it.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      left_q <= 6'h00;
      rx_q   <= `WORD_RST;
      done_q <= 1'b0;
      err_q  <= 1'b0;
    end else if (start_ok) begin
      left_q <= len_q;
      rx_q   <= `WORD_RST;
      done_q <= 1'b0;
      err_q  <= 1'b0;
    end else if (state_q == spi_host_pkg::S_RX && acc_done) begin
      left_q <= left_d;
      rx_q   <= (rx_q << chunk) | {24'h00_0000, acc_rdata & low_mask[7:0]};
      if (cnt_q != chunk) begin
        err_q <= 1'b1;
      end
    end else if (state_q == spi_host_pkg::S_DONE) begin
      done_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin observer: counts sample edges while selected to confirm each chunk.
  // It misses nothing only while SCLK stays well below a quarter of CORE_CLK.
  pin_sync #(.W(4)) u_pins (
    .clk  (CORE_CLK),
    .rst  (RESET),
    .pin  ({SPI_SS_N, SPI_MISO, SPI_MOSI, SPI_SCLK}),
    .lvl  (pin_lvl),
    .rise (pin_rise),
    .fall (pin_fall)
  );

  assign samp = (cpol_q == cpha_q) ? pin_rise[0] : pin_fall[0];

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      cnt_q        <= 4'h0;
      mosi_snoop_q <= 8'h00;
      miso_snoop_q <= 8'h00;
    end else if (state_q == spi_host_pkg::S_EXE && req) begin
      cnt_q <= 4'h0;
    end else if (samp && !pin_lvl[3]) begin
      cnt_q        <= cnt_q + 4'h1;
      mosi_snoop_q <= {mosi_snoop_q[6:0], pin_lvl[1]};
      miso_snoop_q <= {miso_snoop_q[6:0], pin_lvl[2]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_avs_answer;
    @(posedge CORE_CLK) disable iff (RESET)
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endproperty
  a_avs_answer : assert property (p_avs_answer) else $error("bus answer not in one cycle");

  property p_cfg_first;
    @(posedge CORE_CLK) disable iff (RESET)
      req && req_addr == `DEV_REG_EXE && req_wr |-> last_cfg_q[`CFG_EN_BIT];
  endproperty
  a_cfg_first : assert property (p_cfg_first) else $error("trigger without enable");

  property p_split;
    @(posedge CORE_CLK) disable iff (RESET)
      req && req_addr == `DEV_REG_EXE && req_wr |-> last_wr_q == `DEV_REG_CFG;
  endproperty
  a_split : assert property (p_split) else $error("trigger not preceded by config");

  property p_go_value;
    @(posedge CORE_CLK) disable iff (RESET)
      DEV_WRITE && DEV_ADDR == `DEV_REG_EXE |-> DEV_WDATA == 8'h01;
  endproperty
  a_go_value : assert property (p_go_value) else $error("bad trigger value");

  property p_sample;
    @(posedge CORE_CLK) disable iff (RESET)
      samp && !pin_lvl[3] && !(state_q == spi_host_pkg::S_EXE && req)
        |=> cnt_q == $past(cnt_q) + 4'h1;
  endproperty
  a_sample : assert property (p_sample) else $error("sample edge not counted");

  property p_end_ss;
    @(posedge CORE_CLK) disable iff (RESET)
      req && state_q == spi_host_pkg::S_END |-> req_data[`CFG_SS_BIT] && req_wr;
  endproperty
  a_end_ss : assert property (p_end_ss) else $error("frame end keeps select low");

  sequence s_exe_taken;
    state_q == spi_host_pkg::S_EXE && acc_done;
  endsequence
  sequence s_poll_then_rx;
    state_q == spi_host_pkg::S_POLL ##[1:1000] state_q != spi_host_pkg::S_POLL;
  endsequence
  property p_poll_follows;
    @(posedge CORE_CLK) disable iff (RESET)
      s_exe_taken |=> s_poll_then_rx;
  endproperty
  a_poll_follows : assert property (p_poll_follows) else $error("no poll after trigger");

  property p_rx_before_done;
    @(posedge CORE_CLK) disable iff (RESET)
      state_q == spi_host_pkg::S_DONE |->
        $past(state_q) == spi_host_pkg::S_RX || $past(state_q) == spi_host_pkg::S_END;
  endproperty
  a_rx_before_done : assert property (p_rx_before_done) else $error("done without read");

endmodule : spi_frame_host

/* File: tb/dev_model.sv */
// Behavioural device: serial master registers, its pins and one slave behind them.
// Assumes the host holds each register request until the one-cycle ack.
`timescale 1ns/1ns
`include "spi_host_cfg.svh"
module dev_model (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port.
  input  wire logic [7:0]  dev_addr,
  input  wire logic [7:0]  dev_wdata,
  input  wire logic        dev_write,
  input  wire logic        dev_read,
  output logic      [7:0]  dev_rdata,
  output logic             dev_ack,
  // Serial pins.
  output logic             sclk,
  output logic             mosi,
  output logic             miso,
  output logic             ss_n,
  // Bench controls.
  input  wire logic [31:0] slv_data,
  input  wire logic [2:0]  lat,
  input  wire logic        echo,
  output logic             order_err
);
  logic [7:0] cfg_q, tx_q, rx_q, last_q;
  logic       go_q, ph, ss_hold;
  logic [2:0] cnt;
  int         sidx;
  // Select rests high until enabled, as the board pull-up would hold it.
  // In echo mode select keeps the level it had on entry; SCLK and MOSI stay still, MISO toggles only while select is held high.
  assign ss_n = echo ? ss_hold
                     : (cfg_q[`CFG_EN_BIT] ? cfg_q[`CFG_SS_BIT] : 1'b1);
  assign sclk = cfg_q[`CFG_EN_BIT] & (cfg_q[`CFG_CPOL_BIT] ^ ph);
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    dev_ack <= 1'b0;
    dev_rdata <= ~dev_rdata;
    if (!echo) ss_hold <= ss_n;
    if (rst) begin
      {cfg_q, tx_q, rx_q, last_q, dev_rdata} <= 40'h00_0000_0000;
      {go_q, cnt, order_err} <= 5'h00;
    end else if ((dev_write || dev_read) && !dev_ack) begin
      if (cnt != lat) cnt <= cnt + 3'h1;
      else begin
        cnt <= 3'h0;
        dev_ack <= 1'b1;
        case (dev_addr)
          `DEV_REG_CFG: dev_rdata <= cfg_q;
          `DEV_REG_TX: dev_rdata <= tx_q;
          `DEV_REG_RX: dev_rdata <= rx_q;
          `DEV_REG_EXE: dev_rdata <= {7'h00, go_q};
          default: dev_rdata <= 8'h00;
        endcase
        if (dev_write) begin
          last_q <= dev_addr;
          if (dev_addr == `DEV_REG_CFG) cfg_q <= dev_wdata;
          if (dev_addr == `DEV_REG_TX) tx_q <= dev_wdata;
          if (dev_addr == `DEV_REG_EXE && dev_wdata[`EXE_GO_BIT] && !go_q) begin
            go_q <= 1'b1;
            if (last_q != `DEV_REG_CFG) order_err <= 1'b1;
          end
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic shift();
    int         n;
    logic [7:0] r;
    n = (cfg_q[2:0] == 3'h0) ? 8 : int'(cfg_q[2:0]);
    r = rx_q;
    for (int i = n - 1; i >= 0; i--) begin
      if (!cfg_q[`CFG_CPHA_BIT] && !echo) begin
        mosi <= tx_q[i];
        miso <= slv_data[sidx];
      end
      repeat (4) @(posedge clk);
      if (!echo) ph <= 1'b1;
      if (cfg_q[`CFG_CPHA_BIT]) begin
        if (!echo) begin
          mosi <= tx_q[i];
          miso <= slv_data[sidx];
        end
      end else r[i] = echo ? tx_q[i] : miso;
      repeat (4) @(posedge clk);
      ph <= 1'b0;
      if (cfg_q[`CFG_CPHA_BIT]) r[i] = echo ? tx_q[i] : miso;
      sidx = sidx - 1;
    end
    repeat (4) @(posedge clk);
    rx_q <= r;
    go_q <= 1'b0;
  endtask : shift
  // A deselected slave toggles its line so a stale bit is never mistaken for data.
  initial begin
    ph = 1'b0;
    mosi = 1'b0;
    miso = 1'b0;
    sidx = 31;
    forever begin
      @(posedge clk);
      if (ss_n === 1'b1) begin
        sidx = 31;
        miso <= ~miso;
      end
      if (go_q === 1'b1 && !rst) shift();
    end
  end
endmodule : dev_model

/* File: tb/testbench.sv */
// Self-checking bench of the frame host against the behavioural device.
// Assumes the host answers every Avalon request after one wait cycle.
`timescale 1ns/1ns
`include "spi_host_cfg.svh"
module testbench;
  logic        clk, rst, rd, wr, wreq, dwr, drd, ack, sclk, mosi, miso, ss_n, oerr;
  logic        sclk_p, ss_p, cpol, cpha, echo;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata, slv, seed, mon;
  logic [7:0]  daddr, dwdata, drdata;
  logic [2:0]  lat;
  int          errors, n_compared, n_fall, cyc;
  spi_frame_host dut (.CORE_CLK(clk), .RESET(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wreq), .DEV_ADDR(daddr), .DEV_WDATA(dwdata), .DEV_WRITE(dwr),
    .DEV_READ(drd), .DEV_RDATA(drdata), .DEV_ACK(ack), .SPI_SCLK(sclk), .SPI_MOSI(mosi),
    .SPI_MISO(miso), .SPI_SS_N(ss_n));
  dev_model dev (.clk(clk), .rst(rst), .dev_addr(daddr), .dev_wdata(dwdata),
    .dev_write(dwr), .dev_read(drd), .dev_rdata(drdata), .dev_ack(ack), .sclk(sclk),
    .mosi(mosi), .miso(miso), .ss_n(ss_n), .slv_data(slv), .lat(lat), .echo(echo),
    .order_err(oerr));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic summarize();
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t register read %h expected %h", $time, got, exp);
    end
  endtask : cmp_reg
  task automatic cmp_pin(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t pin observation %h expected %h", $time, got, exp);
    end
  endtask : cmp_pin
  // Request held until waitrequest is seen low; only the timeout ends a wait.
  task automatic avs(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : avs
  task automatic frame(input int l, input logic [1:0] md, input logic keep);
    logic [31:0] q, tx, sd, m, rx;
    m = (l == 32) ? 32'hFFFF_FFFF : (32'h0000_0001 << l) - 32'h0000_0001;
    tx = rnd();
    sd = rnd();
    rx = sd >> (32 - l);
    slv <= sd;
    lat <= tx[31:29];
    {cpha, cpol} = md;
    mon = 32'h0000_0000;
    n_fall = 0;
    avs(1'b1, `HR_LEN, l, q);
    avs(1'b1, `HR_TX, tx, q);
    avs(1'b1, `HR_CTRL, {28'h000_0000, keep, md, 1'b1}, q);
    avs(1'b1, `HR_TX, ~tx, q);
    do avs(1'b0, `HR_STAT, 32'h0000_0000, q); while (q[0] !== 1'b0);
    cmp_reg(q, {20'h0_0000, 4'(((l - 1) % 8) + 1), 8'h02});
    avs(1'b0, `HR_RX, 32'h0000_0000, q);
    cmp_reg(q, rx);
    avs(1'b0, `HR_SNOOP, 32'h0000_0000, q);
    if (l >= 8) cmp_reg(q[15:0], {rx[7:0], tx[7:0]});
    cmp_pin(mon & m, tx & m);
    cmp_pin(n_fall, 1);
    cmp_pin(ss_n, !keep);
    cmp_pin(sclk, md[0]);
    cmp_pin(oerr, 1'b0);
  endtask : frame
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Pin monitor: collects MOSI at each sampling edge while selected.
  always @(posedge clk) begin
    sclk_p <= sclk;
    ss_p <= ss_n;
    if (ss_p === 1'b1 && ss_n === 1'b0) n_fall <= n_fall + 1;
    if (ss_n === 1'b0 && sclk_p !== sclk && sclk === (cpol == cpha))
      mon <= {mon[30:0], mosi};
    cyc <= cyc + 1;
    if (cyc >= 60000) begin
      errors++;
      $display("[FAIL] %0t run did not finish in time", $time);
      summarize();
    end
  end
  initial begin
    logic [31:0] q, t;
    logic        e;
    int          l;
    {rst, rd, wr, cpol, cpha} = 5'h10;
    {addr, wdata, slv, lat} = 72'h00_0000_0000_0000_0000;
    {errors, n_compared, n_fall, cyc} = 128'h0;
    seed = 32'h0001_2535;
    echo = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    avs(1'b0, `HR_LEN, 32'h0000_0000, q);
    cmp_reg(q, {26'h000_0000, `LEN_RST});
    avs(1'b0, `HR_CTRL, 32'h0000_0000, q);
    cmp_reg(q, 32'h0000_0000);
    avs(1'b0, 5'h18, 32'h0000_0000, q);
    cmp_reg(q, 32'h0000_0000);
    // Lengths of zero and beyond 32 must not start a frame.
    avs(1'b1, `HR_LEN, 32'h0000_0000, q);
    avs(1'b1, `HR_CTRL, 32'h0000_0001, q);
    avs(1'b0, `HR_STAT, 32'h0000_0000, q);
    cmp_reg(q, 32'h0000_0000);
    avs(1'b1, `HR_LEN, 32'h0000_0021, q);
    avs(1'b1, `HR_CTRL, 32'h0000_0001, q);
    avs(1'b0, `HR_STAT, 32'h0000_0000, q);
    cmp_reg(q, 32'h0000_0000);
    for (int i = 0; i < 16; i++) begin
      l = (i < 8) ? ((i % 4 == 0) ? 1 : (i % 4 == 1) ? 8 : (i % 4 == 2) ? 9 : 32)
                  : int'(rnd() % 32) + 1;
      frame(l, 2'(i + i / 4), i % 3 == 0);
    end
    // Echo frame: no pin edges, so the host must flag err yet still get the byte back.
    t = rnd();
    e = ss_n;
    mon = 32'h0000_0000;
    echo <= 1'b1;
    avs(1'b1, `HR_TX, t, q);
    avs(1'b1, `HR_LEN, 32'h0000_0008, q);
    avs(1'b1, `HR_CTRL, 32'h0000_0001, q);
    do avs(1'b0, `HR_STAT, 32'h0000_0000, q); while (q[0] !== 1'b0);
    cmp_reg(q, 32'h0000_0006);
    avs(1'b0, `HR_RX, 32'h0000_0000, q);
    cmp_reg(q, {24'h00_0000, t[7:0]});
    cmp_pin(mon, 32'h0000_0000);
    cmp_pin(ss_n, e);
    summarize();
  end
endmodule : testbench
